// >>> logic/wdrs_supervisor.sv
// Purpose: window watchdog and reset supervisor, digital core
// Assumes: pin strap states and capacitor times arrive as decoded inputs
// Notes:   times counted in 1 us ticks from a clock divider
// Notes on behaviour
// - reset output driven low in reset period, released in watchdog period
// - watchdog pin on pump rail selects internal 1.6 s upper bound
// - capacitor on watchdog pin sets the upper bound from its time
// - watchdog pin and kick input both grounded disable the watchdog
// - reset pin on pump rail selects internal 200 ms reset time
// - capacitor sets reset length; open pin gives the shortest
// - monitor input below threshold forces reset state, output low
// - after monitor recovers, full reset period elapses before release
// - kick too early or too late asserts the reset output
// - internal timing treats kicks under 50 ms as too early
// - capacitor timing places upper bound at external time times 128/129
`timescale 1ns/100ps
module wdrs_supervisor
	import wdrs_pkg::*;
(
	// clock and reset
	input  wire logic            clock,
	input  wire logic            rst,
	// pins, asynchronous
	input  wire logic            watchdogKickInput,
	input  wire logic            resetMonitorInput,  // high: above threshold
	input  wire wdrs_pin_t       watchdogTimingPin,
	input  wire wdrs_pin_t       resetTimingPin,
	// capacitor-derived times in ticks
	input  wire logic [TW-1:0]   windowCapTicks,
	input  wire logic [TW-1:0]   holdOffCapTicks,
	// open-drain reset output
	output logic                 resetOut,
	output logic                 resetOutEn,
	// status
	output wdrs_stat_t           status
);
	typedef enum logic [1:0] {S_RESET, S_HOLD, S_WATCH} wdrs_state_t;

	// scales a capacitor time by num/129
	function automatic logic [TW-1:0] wdrs_scale(input logic [TW-1:0] t,
		input logic [7:0] num);
		logic [TW+7:0] p;
		p = t * num;
		return TW'(p / (TW+8)'(WDU_EXT_DEN));
	endfunction : wdrs_scale

	logic [1:0]  kickSync;
	logic [1:0]  monSync;
	logic        kickPrev;
	logic [7:0]  divCount;
	logic        tick;
	logic [TW-1:0] timer;
	wdrs_state_t state;
	wdrs_stat_t  next_status;
	wdrs_pin_t   wtPinMeta;
	wdrs_pin_t   wtPinSafe;
	wdrs_pin_t   rtPinMeta;
	wdrs_pin_t   rtPinSafe;

	// two-flop synchronisers for the pins
	always_ff @(posedge clock)
	begin
		kickSync <= {kickSync[0], watchdogKickInput};
		monSync  <= {monSync[0], resetMonitorInput};
		kickPrev <= kickSync[1];
	end

	// strap pins pass two flops too, aligned with the kick synchroniser
	always_ff @(posedge clock)
	begin
		wtPinMeta <= watchdogTimingPin;
		wtPinSafe <= wtPinMeta;
		rtPinMeta <= resetTimingPin;
		rtPinSafe <= rtPinMeta;
	end

	// decoded timing and events
	wire logic          kickFall  = kickPrev & ~kickSync[1];
	wire logic          monLow    = ~monSync[1];
	wire logic          wdOff     = (wtPinSafe == PIN_GND) &
		~kickSync[1];
	wire logic          wdInt     = (wtPinSafe == PIN_RAIL);
	wire logic [TW-1:0] upperTks  = wdInt ? TW'(WDU_INT_TICKS) :
		wdrs_scale(windowCapTicks, 8'(WDU_EXT_NUM));
	wire logic [TW-1:0] lowerTks  = wdInt ? TW'(WDL_INT_TICKS) :
		wdrs_scale(windowCapTicks, 8'(WDL_EXT_NUM));
	wire logic [TW-1:0] resetTks  =
		(rtPinSafe == PIN_RAIL) ? TW'(RST_INT_TICKS) :
		(rtPinSafe == PIN_CAP)  ? holdOffCapTicks :
		TW'(RST_MIN_TICKS);
	wire logic          tooEarly  = kickFall & (timer < lowerTks);
	wire logic          tooLate   = timer >= upperTks;

	// 1 us tick enable
	always_ff @(posedge clock)
	begin
		if (rst)
			divCount <= 8'h00;
		else if (divCount == 8'(TICK_CYCLES - 1))
			divCount <= 8'h00;
		else
			divCount <= divCount + 8'h01;
	end
	assign tick = (divCount == 8'(TICK_CYCLES - 1));

	// supervisor state machine
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state <= S_RESET;
			timer <= '0;
		end
		else if (monLow)
		begin
			state <= S_RESET;
			timer <= '0;
		end
		else
		begin
			case (state)
				S_RESET:
				begin
					state <= S_HOLD;
					timer <= '0;
				end
				S_HOLD:
				begin
					if (tick && timer + 1'b1 >= resetTks)
					begin
						state <= S_WATCH;
						timer <= '0;
					end
					else if (tick)
						timer <= timer + 1'b1;
				end
				S_WATCH:
				begin
					if (wdOff)
						timer <= '0;
					else if (tooEarly || tooLate)
					begin
						state <= S_RESET;
						timer <= '0;
					end
					else if (kickFall)
						timer <= '0;
					else if (tick)
						timer <= timer + 1'b1;
				end
				default:
					state <= S_RESET;
			endcase
		end
	end

	// status flags, faults held until the next valid kick
	always_comb
	begin
		next_status = status;
		next_status.inReset  = (state != S_WATCH) | monLow;
		next_status.wdActive = (state == S_WATCH) & ~wdOff;
		if (state == S_WATCH && !wdOff && !monLow)
		begin
			if (tooEarly)
				next_status.earlyFault = 1'b1;
			if (tooLate && !tooEarly)
				next_status.lateFault = 1'b1;
			if (kickFall && !tooEarly && !tooLate)
			begin
				next_status.earlyFault = 1'b0;
				next_status.lateFault  = 1'b0;
			end
		end
	end

	// registered outputs
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			resetOut   <= 1'b0;
			resetOutEn <= 1'b1;
			status     <= '{inReset: 1'b1, default: 1'b0};
		end
		else
		begin
			resetOut   <= 1'b0;
			resetOutEn <= next_status.inReset;
			status     <= next_status;
		end
	end

	// assertions
	a_reset_drive: assert property (@(posedge clock) disable iff (rst)
		(state != S_WATCH) |=> resetOutEn)
		else $error("reset output not driven during reset period");
	a_monitor_low: assert property (@(posedge clock) disable iff (rst)
		monLow |=> (state == S_RESET))
		else $error("low monitor did not force reset");
	a_late_kick: assert property (@(posedge clock) disable iff (rst)
		(state == S_WATCH && !wdOff && !monLow && tooLate)
		|=> state == S_RESET ##2 resetOutEn)
		else $error("late kick missed");
	a_early_kick: assert property (@(posedge clock) disable iff (rst)
		(state == S_WATCH && !wdOff && !monLow && tooEarly)
		|=> state == S_RESET)
		else $error("early kick missed");
	a_wd_off: assert property (@(posedge clock) disable iff (rst)
		(state == S_WATCH && wdOff && !monLow) |=> state == S_WATCH)
		else $error("disabled watchdog caused reset");
	a_hold_full: assert property (@(posedge clock) disable iff (rst)
		(state == S_HOLD && !tick && !monLow) |=> state == S_HOLD)
		else $error("reset period left early");
	a_kick_restart: assert property (@(posedge clock) disable iff (rst)
		(state == S_WATCH && kickFall && !tooEarly && !tooLate && !monLow)
		|=> timer == '0)
		else $error("valid kick did not restart window");
	a_int_bounds: assert property (@(posedge clock) disable iff (rst)
		(state == S_WATCH && wdInt && !wdOff && !monLow &&
		timer >= TW'(WDU_INT_TICKS)) |=> state == S_RESET)
		else $error("internal upper bound not enforced");
	a_int_lower: assert property (@(posedge clock) disable iff (rst)
		(state == S_WATCH && wdInt && !wdOff && !monLow && kickFall &&
		timer < TW'(WDL_INT_TICKS)) |=> state == S_RESET)
		else $error("internal lower bound not enforced");
endmodule : wdrs_supervisor

// >>> logic/wdrs_pkg.sv
// Purpose: constants and types for the watchdog reset supervisor
// Assumes: 250 MHz clock, analog pins already digitised
// Notes:   times kept in their own units, tick counts derived here
package wdrs_pkg;
	localparam int unsigned CLK_MHZ        = 250;
	localparam int unsigned TICK_CYCLES    = 250;        // one tick = 1 us
	localparam int unsigned RST_INT_MS     = 200;        // internal reset time
	localparam int unsigned WDU_INT_MS     = 1600;       // internal upper bound
	localparam int unsigned WDL_INT_MS     = 50;         // internal lower bound
	localparam int unsigned RST_INT_TICKS  = RST_INT_MS * 1000;
	localparam int unsigned WDU_INT_TICKS  = WDU_INT_MS * 1000;
	localparam int unsigned WDL_INT_TICKS  = WDL_INT_MS * 1000;
	localparam int unsigned RST_MIN_TICKS  = 1;          // open reset pin
	localparam int unsigned WDU_EXT_NUM    = 128;        // upper = ext*128/129
	localparam int unsigned WDU_EXT_DEN    = 129;
	localparam int unsigned WDL_EXT_NUM    = 5;          // lower = ext*5/129
	localparam int unsigned TW             = 24;         // tick counter width

	// how a timing pin is strapped
	typedef enum logic [1:0] {
		PIN_RAIL,      // tied to pump output rail
		PIN_CAP,       // capacitor to ground
		PIN_OPEN,      // left open
		PIN_GND        // tied to ground
	} wdrs_pin_t;

	// supervisor status bundle
	typedef struct packed {
		logic inReset;
		logic wdActive;
		logic earlyFault;
		logic lateFault;
	} wdrs_stat_t;
endpackage : wdrs_pkg

// >>> tb/wdrs_host.sv
// Purpose: host model that kicks the watchdog pin
// Assumes: reset wire already resolved with its pull-up
// Notes:   kicks restart from each reset release; pin never floats
`timescale 1ns/100ps
module wdrs_host
	import wdrs_pkg::*;
(
	// clock
	input  wire logic        clock,
	// commands from the bench
	input  wire logic [15:0] gapCycles,
	input  wire logic        parkLow,
	// pins
	input  wire logic        resetWire,
	output logic             kickPin
);
	logic [15:0] count;
	// start high so the pin is defined from time zero
	initial
	begin
		kickPin = 1'b1;
		count = 16'h0000;
	end
	// falling edge every gapCycles, pin low for 50 cycles
	always @(negedge clock)
	begin
		if (parkLow)
			kickPin <= 1'b0;
		else if (!resetWire || gapCycles == 16'h0000)
		begin
			count <= 16'h0000;
			kickPin <= 1'b1;
		end
		else
		begin
			count <= count + 16'h0001;
			if (count == gapCycles - 16'h0001)
			begin
				kickPin <= 1'b0;
				count <= 16'h0000;
			end
			else if (count == 16'h0031)
				kickPin <= 1'b1;
		end
	end
endmodule : wdrs_host

// >>> tb/tb_top.sv
// Purpose: scenario bench for the watchdog reset supervisor
// Assumes: capacitor modes keep runs short (hold 4, window 64 ticks)
// Notes:   window 64 gives lower 2 and upper 63 ticks
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errTotal++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top
	import wdrs_pkg::*;
;
	logic clock, rst, kickPin, monitor, parkLow, resetOut, resetOutEn;
	wdrs_pin_t wdPin, rtPin;
	logic [TW-1:0] winTicks, holdTicks;
	logic [15:0] gapCycles;
	wdrs_stat_t status;
	int errTotal, compares;
	wire resetWire = resetOutEn ? resetOut : 1'b1; // pull-up when released
	// design and host
	wdrs_supervisor dut (.clock(clock), .rst(rst), .watchdogKickInput(kickPin),
		.resetMonitorInput(monitor), .watchdogTimingPin(wdPin),
		.resetTimingPin(rtPin), .windowCapTicks(winTicks),
		.holdOffCapTicks(holdTicks), .resetOut(resetOut),
		.resetOutEn(resetOutEn), .status(status));
	wdrs_host host (.clock(clock), .gapCycles(gapCycles), .parkLow(parkLow),
		.resetWire(resetWire), .kickPin(kickPin));
	// 250 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// verdict and end of run
	task automatic stop_test();
		$display("errors %0d compares %0d", errTotal, compares);
		if (errTotal == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	// bounded wait for the enable to reach v
	task automatic waitEn(input logic v, input int n);
		int i;
		for (i = 0; i < n && resetOutEn !== v; i++)
			@(negedge clock);
		if (resetOutEn !== v)
		begin
			errTotal++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, resetOutEn, v);
			stop_test();
		end
	endtask : waitEn
	// enable must hold v for n cycles
	task automatic stay(input logic v, input int n);
		int i;
		for (i = 0; i < n && resetOutEn === v; i++)
			@(negedge clock);
		`CHK(resetOutEn, v)
	endtask : stay
	// monitor drop and recovery with capacitor hold-off
	task automatic s_hold();
		rtPin = PIN_CAP;
		monitor = 1'b0;
		waitEn(1'b1, 10);
		`CHK(resetOut, 1'b0)
		`CHK(status.inReset, 1'b1)
		monitor = 1'b1;
		stay(1'b1, 750);
		waitEn(1'b0, 600);
		`CHK(status.inReset, 1'b0)
	endtask : s_hold
	// regular kicks keep the output released well past upper bound
	task automatic s_kick();
		gapCycles = 16'd2500;
		stay(1'b0, 20000);
		`CHK(status.lateFault, 1'b0)
		`CHK(status.wdActive, 1'b1)
	endtask : s_kick
	// missing kicks fire reset, then a full hold-off follows
	task automatic s_late();
		gapCycles = 16'h0000;
		waitEn(1'b1, 17000);
		`CHK(status.lateFault, 1'b1)
		stay(1'b1, 750);
		waitEn(1'b0, 600);
		stay(1'b0, 15450);
		waitEn(1'b1, 400);
		waitEn(1'b0, 1600);
	endtask : s_late
	// kick one tick after release is too early
	task automatic s_early();
		gapCycles = 16'd250;
		waitEn(1'b1, 1000);
		`CHK(status.earlyFault, 1'b1)
		gapCycles = 16'h0000;
		waitEn(1'b0, 1600);
	endtask : s_early
	// grounded timing pin and kick disable supervision
	task automatic s_off();
		wdPin = PIN_GND;
		parkLow = 1'b1;
		stay(1'b0, 17500);
		`CHK(status.wdActive, 1'b0)
		rtPin = PIN_RAIL;
		monitor = 1'b0;
		waitEn(1'b1, 10);
		monitor = 1'b1;
		stay(1'b1, 2000);
	endtask : s_off
	// main sequence
	initial
	begin
		errTotal = 0;
		compares = 0;
		rst = 1'b1;
		monitor = 1'b1;
		parkLow = 1'b0;
		gapCycles = 16'h0000;
		wdPin = PIN_CAP;
		rtPin = PIN_OPEN;
		winTicks = 24'h000040;
		holdTicks = 24'h000004;
		repeat (6) @(negedge clock);
		rst = 1'b0;
		`CHK(resetOutEn, 1'b1)
		waitEn(1'b0, 600);
		s_hold();
		s_kick();
		s_late();
		s_early();
		s_off();
		stop_test();
	end
endmodule : tb_top
